// File: core/bcm_exec.sv
// execution of jumps, relative branches, long call and byte moves
`timescale 1ns/1ps
`default_nettype none
module bcm_exec (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // instruction from fetch
  input wire bcm_pkg::bcm_instr_type instr,
  output logic ready,
  output logic done,
  output logic illegal,
  // architectural state
  output bcm_pkg::bcm_arch_type arch
);

  typedef struct packed {
    bcm_pkg::bcm_state_type st;
    bcm_pkg::bcm_instr_type ins;
    bcm_pkg::bcm_arch_type arch;
    logic [7:0] hold;
    logic src_ram;
    logic ready;
    logic done;
    logic illegal;
  } bcm_exec_state_type;

  bcm_exec_state_type state_reg;
  bcm_exec_state_type state_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;

  logic ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_raddr;
  logic [7:0] ram_rdata;

  assign rst_n = rst_sync_reg[1];
  assign ready = state_reg.ready;
  assign done = state_reg.done;
  assign illegal = state_reg.illegal;
  assign arch = state_reg.arch;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  bcm_ram #(
    .WIDTH(bcm_pkg::RAM_WIDTH),
    .DEPTH(bcm_pkg::RAM_DEPTH)
  ) u_ram (
    .clock(clock),
    .clock_en(clock_en),
    .write_en(ram_we),
    .write_addr(ram_waddr),
    .write_data(ram_wdata),
    .read_addr(ram_raddr),
    .read_data(ram_rdata)
  );

  // classify an opcode into source, destination and length
  function automatic bcm_pkg::bcm_dec_type decode(input logic [7:0] op);
    bcm_pkg::bcm_dec_type d;
    d = '{legal: 1'b1, move: 1'b1, src: bcm_pkg::K_NONE, dst: bcm_pkg::K_NONE,
          len: bcm_pkg::LEN_ONE};
    casez (op)
      8'h73: begin
        d.move = 1'b0;
      end
      8'h30, 8'h12, 8'h02: begin
        d.move = 1'b0;
        d.len = bcm_pkg::LEN_THREE;
      end
      8'h50, 8'h60, 8'h70: begin
        d.move = 1'b0;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'b1110_1???: begin
        d.src = bcm_pkg::K_REG;
        d.dst = bcm_pkg::K_ACC;
      end
      8'he5: begin
        d.src = bcm_pkg::K_DIR;
        d.dst = bcm_pkg::K_ACC;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'b1110_011?: begin
        d.src = bcm_pkg::K_IND;
        d.dst = bcm_pkg::K_ACC;
      end
      8'h74: begin
        d.src = bcm_pkg::K_IMM;
        d.dst = bcm_pkg::K_ACC;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'b1111_1???: begin
        d.src = bcm_pkg::K_ACC;
        d.dst = bcm_pkg::K_REG;
      end
      8'b1010_1???: begin
        d.src = bcm_pkg::K_DIR;
        d.dst = bcm_pkg::K_REG;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'b0111_1???: begin
        d.src = bcm_pkg::K_IMM;
        d.dst = bcm_pkg::K_REG;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'hf5: begin
        d.src = bcm_pkg::K_ACC;
        d.dst = bcm_pkg::K_DIR;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'b1000_1???: begin
        d.src = bcm_pkg::K_REG;
        d.dst = bcm_pkg::K_DIR;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'h85: begin
        d.src = bcm_pkg::K_DIR;
        d.dst = bcm_pkg::K_DIR;
        d.len = bcm_pkg::LEN_THREE;
      end
      8'b1000_011?: begin
        d.src = bcm_pkg::K_IND;
        d.dst = bcm_pkg::K_DIR;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'h75: begin
        d.src = bcm_pkg::K_IMM;
        d.dst = bcm_pkg::K_DIR;
        d.len = bcm_pkg::LEN_THREE;
      end
      8'b1111_011?: begin
        d.src = bcm_pkg::K_ACC;
        d.dst = bcm_pkg::K_IND;
      end
      8'b1010_011?: begin
        d.src = bcm_pkg::K_DIR;
        d.dst = bcm_pkg::K_IND;
        d.len = bcm_pkg::LEN_TWO;
      end
      8'b0111_011?: begin
        d.src = bcm_pkg::K_IMM;
        d.dst = bcm_pkg::K_IND;
        d.len = bcm_pkg::LEN_TWO;
      end
      default: begin
        d.legal = 1'b0;
        d.move = 1'b0;
      end
    endcase
    return d;
  endfunction : decode

  // special function register read; unmapped addresses read zero
  function automatic logic [7:0] sfr_read(input logic [7:0] a, input bcm_pkg::bcm_arch_type r);
    logic [7:0] v;
    v = 8'h00;
    if (a == bcm_pkg::SFR_ACC) v = r.acc;
    if (a == bcm_pkg::SFR_STACK_POINTER) v = r.sp;
    if (a == bcm_pkg::SFR_DATA_POINTER_LO) v = r.data_ptr[7:0];
    if (a == bcm_pkg::SFR_DATA_POINTER_HI) v = r.data_ptr[15:8];
    if (a == bcm_pkg::SFR_STATUS) v = r.status;
    return v;
  endfunction : sfr_read

  bcm_pkg::bcm_instr_type cur;
  bcm_pkg::bcm_dec_type dec;
  logic [1:0] bank;
  logic [7:0] reg_addr;
  logic [7:0] ptr_addr;
  logic [7:0] dst_dir;
  logic [7:0] imm;
  logic [7:0] rel;
  logic [15:0] pc_seq;
  logic [15:0] pc_rel;
  logic [7:0] value;
  logic [7:0] tested;
  logic taken;

  always_comb begin
    cur = (state_reg.st == bcm_pkg::S_IDLE) ? instr : state_reg.ins;
    dec = decode(cur.opcode);
    bank = state_reg.arch.status[bcm_pkg::STATUS_BANK_HI:bcm_pkg::STATUS_BANK_LO];
    reg_addr = {3'h0, bank, cur.opcode[2:0]};
    ptr_addr = {3'h0, bank, 2'h0, cur.opcode[0]};
    dst_dir = (cur.opcode == bcm_pkg::OP_MOVE_DIR_DIR) ? cur.op2 : cur.op1;
    imm = (cur.opcode == bcm_pkg::OP_MOVE_DIR_IMM) ? cur.op2 : cur.op1;
    rel = (cur.opcode == bcm_pkg::OP_BRANCH_BIT_CLEAR) ? cur.op2 : cur.op1;
    pc_seq = state_reg.arch.pc + {14'h0, dec.len};
    pc_rel = pc_seq + {{8{rel[7]}}, rel};
    value = state_reg.src_ram ? ram_rdata : state_reg.hold;
    tested = state_reg.src_ram ? ram_rdata : state_reg.hold;
    taken = 1'b0;
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.illegal = 1'b0;
    ram_we = 1'b0;
    ram_waddr = 8'h00;
    ram_wdata = 8'h00;
    ram_raddr = 8'h00;
    unique case (state_reg.st)
      bcm_pkg::S_IDLE: begin
        if (instr.valid) begin
          state_next.ins = instr;
          state_next.src_ram = 1'b0;
          if (!dec.legal) begin
            state_next.done = 1'b1;
            state_next.illegal = 1'b1;
          end else if (dec.move) begin
            state_next.ready = 1'b0;
            state_next.st = bcm_pkg::S_SRC;
            unique case (dec.src)
              bcm_pkg::K_ACC: state_next.hold = state_reg.arch.acc;
              bcm_pkg::K_IMM: state_next.hold = imm;
              bcm_pkg::K_REG: begin
                ram_raddr = reg_addr;
                state_next.src_ram = 1'b1;
              end
              bcm_pkg::K_DIR: begin
                if (cur.op1[7]) begin
                  state_next.hold = sfr_read(cur.op1, state_reg.arch);
                end else begin
                  ram_raddr = cur.op1;
                  state_next.src_ram = 1'b1;
                end
              end
              default: begin
                ram_raddr = ptr_addr;
                state_next.st = bcm_pkg::S_SRC_PTR;
              end
            endcase
          end else begin
            state_next.ready = 1'b0;
            state_next.st = bcm_pkg::S_BRANCH;
            if (cur.opcode == bcm_pkg::OP_BRANCH_BIT_CLEAR) begin
              if (cur.op1[7]) begin
                state_next.hold = sfr_read({cur.op1[7:3], 3'h0}, state_reg.arch);
              end else begin
                ram_raddr = bcm_pkg::BIT_AREA_BASE + {4'h0, cur.op1[6:3]};
                state_next.src_ram = 1'b1;
              end
            end
            if (cur.opcode == bcm_pkg::OP_LONG_CALL) begin
              ram_we = 1'b1;
              ram_waddr = state_reg.arch.sp + 8'h01;
              ram_wdata = pc_seq[7:0];
              state_next.arch.sp = state_reg.arch.sp + 8'h01;
              state_next.hold = pc_seq[15:8];
            end
          end
        end
      end
      bcm_pkg::S_SRC_PTR: begin
        ram_raddr = ram_rdata;
        state_next.src_ram = 1'b1;
        state_next.st = bcm_pkg::S_SRC;
      end
      bcm_pkg::S_SRC: begin
        state_next.st = bcm_pkg::S_IDLE;
        state_next.ready = 1'b1;
        state_next.done = 1'b1;
        state_next.arch.pc = pc_seq;
        unique case (dec.dst)
          bcm_pkg::K_ACC: state_next.arch.acc = value;
          bcm_pkg::K_REG: begin
            ram_we = 1'b1;
            ram_waddr = reg_addr;
            ram_wdata = value;
          end
          bcm_pkg::K_DIR: begin
            if (dst_dir[7]) begin
              if (dst_dir == bcm_pkg::SFR_ACC) state_next.arch.acc = value;
              if (dst_dir == bcm_pkg::SFR_STACK_POINTER) state_next.arch.sp = value;
              if (dst_dir == bcm_pkg::SFR_DATA_POINTER_LO) state_next.arch.data_ptr[7:0] = value;
              if (dst_dir == bcm_pkg::SFR_DATA_POINTER_HI) state_next.arch.data_ptr[15:8] = value;
              if (dst_dir == bcm_pkg::SFR_STATUS) state_next.arch.status = value;
            end else begin
              ram_we = 1'b1;
              ram_waddr = dst_dir;
              ram_wdata = value;
            end
          end
          default: begin
            ram_raddr = ptr_addr;
            state_next.hold = value;
            state_next.src_ram = 1'b0;
            state_next.st = bcm_pkg::S_DST_PTR;
            state_next.ready = 1'b0;
            state_next.done = 1'b0;
            state_next.arch.pc = state_reg.arch.pc;
          end
        endcase
      end
      bcm_pkg::S_DST_PTR: begin
        ram_we = 1'b1;
        ram_waddr = ram_rdata;
        ram_wdata = state_reg.hold;
        state_next.arch.pc = pc_seq;
        state_next.st = bcm_pkg::S_IDLE;
        state_next.ready = 1'b1;
        state_next.done = 1'b1;
      end
      bcm_pkg::S_BRANCH: begin
        state_next.st = bcm_pkg::S_IDLE;
        state_next.ready = 1'b1;
        state_next.done = 1'b1;
        state_next.arch.pc = pc_seq;
        unique case (cur.opcode)
          bcm_pkg::OP_INDIRECT_JUMP: begin
            state_next.arch.pc = state_reg.arch.data_ptr + {8'h00, state_reg.arch.acc};
          end
          bcm_pkg::OP_BRANCH_BIT_CLEAR: begin
            taken = ~tested[cur.op1[2:0]];
          end
          bcm_pkg::OP_BRANCH_CARRY_CLEAR: begin
            taken = ~state_reg.arch.status[bcm_pkg::STATUS_CARRY_BIT];
          end
          bcm_pkg::OP_BRANCH_ACC_NONZERO: begin
            taken = |state_reg.arch.acc;
          end
          bcm_pkg::OP_BRANCH_ACC_ZERO: begin
            taken = ~|state_reg.arch.acc;
          end
          bcm_pkg::OP_LONG_CALL: begin
            ram_we = 1'b1;
            ram_waddr = state_reg.arch.sp + 8'h01;
            ram_wdata = state_reg.hold;
            state_next.arch.sp = state_reg.arch.sp + 8'h01;
            state_next.arch.pc = {cur.op1, cur.op2};
          end
          default: begin
            state_next.arch.pc = {cur.op1, cur.op2};
          end
        endcase
        if (taken) begin
          state_next.arch.pc = pc_rel;
        end
      end
      default: begin
        state_next.st = bcm_pkg::S_IDLE;
        state_next.ready = 1'b1;
      end
    endcase
    // frozen state must not write the ram either
    if (!clock_en) begin
      ram_we = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{st: bcm_pkg::S_IDLE, ins: '0,
                     arch: '{pc: bcm_pkg::PC_RESET, acc: bcm_pkg::ACC_RESET,
                             data_ptr: bcm_pkg::DATA_PTR_RESET, sp: bcm_pkg::SP_RESET,
                             status: bcm_pkg::STATUS_RESET},
                     hold: 8'h00, src_ram: 1'b0, ready: 1'b1, done: 1'b0, illegal: 1'b0};
    end else if (clock_en) begin
      state_reg <= state_next;
    end
  end

endmodule : bcm_exec
`default_nettype wire

// File: core/bcm_pkg.sv
// constants, types and the state encoding of the branch, call and move execution block
//
// Summary of operation
// - indirect jump loads accumulator plus data pointer
// - indirect jump keeps accumulator, pointer, flags
// - bit-clear branch: pc plus three, test bit
// - signed displacement added after pc advance
// - carry-clear branch: pc plus two, carry kept
// - accumulator nonzero branch, nothing modified
// - accumulator zero branch, nothing modified
// - call pushes pc plus three, low first
// - call loads target high then low byte
// - long jump loads full target, no flags
// - byte move copies source, nothing else changes
// - bit-clear branch never writes the tested bit
// - call and jump targets span 64K
package bcm_pkg;

  // opcodes of the instruction group
  localparam logic [7:0] OP_INDIRECT_JUMP = 8'h73;
  localparam logic [7:0] OP_BRANCH_BIT_CLEAR = 8'h30;
  localparam logic [7:0] OP_BRANCH_CARRY_CLEAR = 8'h50;
  localparam logic [7:0] OP_BRANCH_ACC_NONZERO = 8'h70;
  localparam logic [7:0] OP_BRANCH_ACC_ZERO = 8'h60;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_MOVE_DIR_DIR = 8'h85;
  localparam logic [7:0] OP_MOVE_DIR_IMM = 8'h75;

  // special function register addresses reachable by direct moves
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_STACK_POINTER = 8'h81;
  localparam logic [7:0] SFR_DATA_POINTER_LO = 8'h82;
  localparam logic [7:0] SFR_DATA_POINTER_HI = 8'h83;
  localparam logic [7:0] SFR_STATUS = 8'hd0;

  // status word fields
  localparam int STATUS_CARRY_BIT = 7;
  localparam int STATUS_BANK_LO = 3;
  localparam int STATUS_BANK_HI = 4;

  // bit-addressable ram area base
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;

  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] DATA_PTR_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // internal ram geometry
  localparam int RAM_WIDTH = 8;
  localparam int RAM_DEPTH = 256;

  typedef enum logic [2:0] {
    K_NONE,
    K_ACC,
    K_REG,
    K_DIR,
    K_IND,
    K_IMM
  } bcm_kind_type;

  typedef enum logic [2:0] {
    S_IDLE,
    S_SRC_PTR,
    S_SRC,
    S_DST_PTR,
    S_BRANCH
  } bcm_state_type;

  // instruction bytes handed over by fetch
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } bcm_instr_type;

  // architectural state owned by the block
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] acc;
    logic [15:0] data_ptr;
    logic [7:0] sp;
    logic [7:0] status;
  } bcm_arch_type;

  typedef struct packed {
    logic legal;
    logic move;
    bcm_kind_type src;
    bcm_kind_type dst;
    logic [1:0] len;
  } bcm_dec_type;

endpackage : bcm_pkg

// File: core/bcm_ram.sv
// internal data ram with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module bcm_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic clock,
  input wire logic clock_en,
  // write port
  input wire logic write_en,
  input wire logic [AW-1:0] write_addr,
  input wire logic [WIDTH-1:0] write_data,
  // read port
  input wire logic [AW-1:0] read_addr,
  output logic [WIDTH-1:0] read_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clock) begin
    if (clock_en) begin
      if (write_en) begin
        mem_reg[write_addr] <= write_data;
      end
      read_data <= mem_reg[read_addr];
    end
  end

endmodule : bcm_ram
`default_nettype wire

// File: tb/bcm_exec_monitor.sv
// port checks for the branch, call and move execution block
`timescale 1ns/1ps
`default_nettype none
module bcm_exec_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // instruction port
  input wire bcm_pkg::bcm_instr_type instr,
  input wire logic ready,
  input wire logic done,
  input wire logic illegal,
  // state
  input wire bcm_pkg::bcm_arch_type arch
);
  bcm_pkg::bcm_instr_type q_reg;
  bcm_pkg::bcm_arch_type b_reg;
  logic take;
  logic [15:0] rs;
  logic [15:0] rl;
  logic [15:0] p2;
  logic [15:0] p3;
  assign take = clock_en && ready && instr.valid;
  assign rs = {{8{q_reg.op1[7]}}, q_reg.op1};
  assign rl = {{8{q_reg.op2[7]}}, q_reg.op2};
  assign p2 = b_reg.pc + 16'h0002;
  assign p3 = b_reg.pc + 16'h0003;
  // snapshot of instruction and state at the take edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q_reg <= '0;
      b_reg <= '0;
    end else if (take) begin
      q_reg <= instr;
      b_reg <= arch;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    take;
  endsequence
  sequence s_end(logic [7:0] code);
    done && q_reg.opcode == code;
  endsequence
  chk_ijmp_sum: assert property (
    s_end(8'h73) |-> arch.pc == {8'h00, b_reg.acc} + b_reg.data_ptr)
    else $error("indirect jump target wrong");
  chk_ijmp_keep: assert property (
    s_end(8'h73) |-> arch.acc == b_reg.acc && arch.data_ptr == b_reg.data_ptr
    && arch.status == b_reg.status)
    else $error("indirect jump changed state");
  chk_bit_branch: assert property (
    s_end(8'h30) |-> arch.pc == p3 || arch.pc == p3 + rl)
    else $error("bit branch target wrong");
  chk_bit_keep: assert property (
    s_end(8'h30) |-> arch.acc == b_reg.acc && arch.status == b_reg.status
    && arch.sp == b_reg.sp && arch.data_ptr == b_reg.data_ptr)
    else $error("bit branch changed state");
  chk_carry_branch: assert property (
    s_end(8'h50) |-> arch.status == b_reg.status
    && arch.pc == (b_reg.status[7] ? p2 : p2 + rs))
    else $error("carry branch wrong");
  chk_nonzero_branch: assert property (
    s_end(8'h70) |-> arch.acc == b_reg.acc && arch.status == b_reg.status
    && arch.pc == ((b_reg.acc != 8'h00) ? p2 + rs : p2))
    else $error("nonzero branch wrong");
  chk_zero_branch: assert property (
    s_end(8'h60) |-> arch.status == b_reg.status && arch.acc == b_reg.acc
    && arch.pc == ((b_reg.acc == 8'h00) ? p2 + rs : p2))
    else $error("zero branch wrong");
  chk_call_target: assert property (
    s_end(8'h12) |-> arch.pc == {q_reg.op1, q_reg.op2}
    && arch.sp == b_reg.sp + 8'h02)
    else $error("call target or stack wrong");
  chk_jump_target: assert property (
    s_end(8'h02) |-> arch.pc == {q_reg.op1, q_reg.op2}
    && arch.status == b_reg.status && arch.acc == b_reg.acc)
    else $error("long jump wrong");
  chk_move_keep: assert property (
    (s_end(8'h85) ##0 q_reg.op2 < 8'h80) |-> arch.pc == p3 && arch.acc == b_reg.acc
    && arch.data_ptr == b_reg.data_ptr && arch.sp == b_reg.sp)
    else $error("move changed other state");
  chk_illegal_keep: assert property (illegal |-> done && arch == b_reg)
    else $error("illegal opcode changed state");
  chk_done_single: assert property (done && clock_en && !take |=> !done)
    else $error("done held too long");
  chk_ready_done: assert property (s_take |=> ready == done)
    else $error("ready and done disagree");
endmodule : bcm_exec_monitor
bind bcm_exec bcm_exec_monitor u_monitor (.clock(clock), .reset_n(reset_n),
  .clock_en(clock_en), .instr(instr), .ready(ready), .done(done), .illegal(illegal),
  .arch(arch));
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the branch, call and move execution block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock;
  logic reset_n;
  logic clock_en;
  bcm_pkg::bcm_instr_type instr;
  logic ready;
  logic done;
  logic illegal;
  bcm_pkg::bcm_arch_type arch;
  int err_count;
  int cmp_count;
  int cyc;
  int m_pc, m_acc, m_dp, m_sp, m_st, m_ln, m_lat, m_ill;
  int ram [256];
  logic [31:0] seed;
  logic [7:0] op_base [24] = '{8'h73, 8'h30, 8'h50, 8'h70, 8'h60, 8'h12, 8'h02, 8'h74,
    8'he8, 8'he5, 8'he6, 8'hf8, 8'h78, 8'ha8, 8'hf5, 8'h88, 8'h85, 8'h86, 8'h75, 8'hf6,
    8'ha6, 8'h76, 8'h00, 8'h40};

  bcm_exec u_dut (.clock(clock), .reset_n(reset_n), .clock_en(clock_en), .instr(instr),
    .ready(ready), .done(done), .illegal(illegal), .arch(arch));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic int sx(int v);
    return v > 127 ? v - 256 : v;
  endfunction : sx

  // direct space: low half is ram, upper half the modelled registers
  function automatic int rd(int a);
    if (a < 128) return ram[a];
    case (a)
      8'he0: return m_acc;
      8'h81: return m_sp;
      8'h82: return m_dp & 255;
      8'h83: return m_dp >> 8;
      8'hd0: return m_st;
      default: return 0;
    endcase
  endfunction : rd

  task automatic wr(int a, int v);
    if (a < 128) ram[a] = v;
    else case (a)
      8'he0: m_acc = v;
      8'h81: m_sp = v;
      8'h82: m_dp = (m_dp & 65280) | v;
      8'h83: m_dp = (m_dp & 255) | (v << 8);
      8'hd0: m_st = v;
      default: ;
    endcase
  endtask : wr

  task automatic mv(int ind, int d, int v, int l);
    if (ind) ram[d] = v;
    else wr(d, v);
    m_ln = l;
  endtask : mv

  task automatic mexec(input int op, input int a, input int b);
    int wk, ix, bv;
    wk = ((m_st >> 3) & 3) * 8 + (op & 7);
    ix = ram[((m_st >> 3) & 3) * 8 + (op & 1)];
    m_ln = 0;
    m_ill = 0;
    casez (8'(op))
      8'h73: m_pc = m_acc + m_dp;
      8'h30: begin
        bv = (rd(a < 128 ? 32 + (a >> 3) : a & 248) >> (a & 7)) & 1;
        m_pc += 3 + (bv ? 0 : sx(b));
      end
      8'h50: m_pc += 2 + (((m_st >> 7) & 1) ? 0 : sx(a));
      8'h70: m_pc += 2 + (m_acc != 0 ? sx(a) : 0);
      8'h60: m_pc += 2 + (m_acc == 0 ? sx(a) : 0);
      8'h12: begin
        bv = m_pc + 3;
        m_sp = (m_sp + 1) & 255;
        ram[m_sp] = bv & 255;
        m_sp = (m_sp + 1) & 255;
        ram[m_sp] = (bv >> 8) & 255;
        m_pc = a * 256 + b;
      end
      8'h02: m_pc = a * 256 + b;
      8'h74: mv(0, 8'he0, a, 2);
      8'b1110_1???: mv(0, 8'he0, ram[wk], 1);
      8'he5: mv(0, 8'he0, rd(a), 2);
      8'b1110_011?: mv(0, 8'he0, ram[ix], 1);
      8'b1111_1???: mv(0, wk, m_acc, 1);
      8'b0111_1???: mv(0, wk, a, 2);
      8'b1010_1???: mv(0, wk, rd(a), 2);
      8'hf5: mv(0, a, m_acc, 2);
      8'b1000_1???: mv(0, a, ram[wk], 2);
      8'h85: mv(0, b, rd(a), 3);
      8'b1000_011?: mv(0, a, ram[ix], 2);
      8'h75: mv(0, a, b, 3);
      8'b1111_011?: mv(1, ix, m_acc, 1);
      8'b1010_011?: mv(1, ix, rd(a), 2);
      8'b0111_011?: mv(1, ix, a, 2);
      default: m_ill = 1;
    endcase
    m_lat = m_ill ? 0 : ((op & 14) == 6 ? 2 : 1);
    m_pc = (m_pc + m_ln) & 65535;
  endtask : mexec

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // offer one instruction, stall the clock enable at random, wait for done
  task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    int n;
    int g;
    mexec(op, a, b);
    instr = {1'b1, op, a, b};
    clock_en = (rnd() & 3) != 0;
    @(posedge clock);
    while (clock_en !== 1'b1) begin
      @(negedge clock);
      clock_en = 1'b1;
      @(posedge clock);
    end
    n = 0;
    g = 0;
    @(negedge clock);
    while (done !== 1'b1 && g < 20) begin
      instr.valid = 1'b0;
      clock_en = (rnd() & 3) != 0;
      @(posedge clock);
      n += clock_en;
      @(negedge clock);
      g++;
    end
    check(64'(n), 64'(m_lat));
    check(64'(illegal), 64'(m_ill));
    check(arch, {16'(m_pc), 8'(m_acc), 16'(m_dp), 8'(m_sp), 8'(m_st)});
  endtask : run

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    int a;
    logic [7:0] op;
    logic [7:0] o1;
    reset_n = 1'b0;
    clock_en = 1'b0;
    instr = '0;
    seed = 32'h7a296b3e;
    m_pc = 0;
    m_acc = 0;
    m_dp = 0;
    m_sp = 7;
    m_st = 0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    check(arch, {bcm_pkg::PC_RESET, bcm_pkg::ACC_RESET, bcm_pkg::DATA_PTR_RESET,
      bcm_pkg::SP_RESET, bcm_pkg::STATUS_RESET});
    // fill the whole ram so every later read is known
    for (a = 8; a < 256; a++) begin
      run(8'h78, 8'(a), 8'h00);
      run(8'h76, 8'(rnd()), 8'h00);
    end
    for (a = 0; a < 8; a++) run(8'h75, 8'(a), 8'(rnd()));
    repeat (2000) begin
      a = rnd() % 24;
      op = op_base[a] | (op_base[a][3] ? 8'(rnd() & 7) :
        (op_base[a][2:0] == 3'h6 ? 8'(rnd() & 1) : 8'h00));
      o1 = 8'(rnd());
      // now and then aim a direct form at the status word to move bank and carry
      if ((rnd() & 15) == 0) o1 = 8'hd0;
      if (op == 8'he5 && o1 == 8'he0) o1 = 8'he1;
      run(op, o1, 8'(rnd()));
    end
    instr.valid = 1'b0;
    clock_en = 1'b1;
    repeat (2) @(negedge clock);
    check(64'(done), 64'h0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
